//--- logic/link_ready_timer.sv
/*
  Stabilisation timer for the link monitor: counts cycles while its
  start input stays high and flags when the wait is over.
  Assumes start is a clean level on clk.
*/
`timescale 1ns/1ns
module link_ready_timer #(
  parameter int WAIT_CYC = 8250000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  output logic      done
);

  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic        done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (!start) begin
      cnt_nxt = 24'h000000;
    end else if (cnt_r >= 24'(WAIT_CYC - 1)) begin
      done_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 24'h000000;
      done  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done  <= done_nxt & start;
    end
  end

endmodule

//--- logic/phy_carrier_col_link_loopback.sv
/*
  Media-side status and test logic of a 10/100 transceiver: carrier sense
  from received code groups, collision detect and collision test, the
  100 Mb/s link monitor with its 10 Mb/s multiplex, near-end loopback, and remote echo in RMII mode only.
  Assumes the code-group stream arrives one bit per clock on the core
  clock, tx/rx clocks and MAC pins are asynchronous, and register access
  is a simple index/strobe management port.
*/
`timescale 1ns/1ns
module phy_carrier_col_link_loopback
  import phy_link_pkg::*;
#(
  parameter longint LINK_WAIT = LINK_WAIT_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Management port
  input  wire logic [4:0] reg_index,
  input  wire logic       reg_write,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]     reg_rdata,
  // Configuration
  input  wire logic       rmii_mode,
  input  wire logic       repeater_mode,
  input  wire logic       speed_10,
  // Media side
  input  wire logic       rx_code_bit,
  input  wire logic       signal_good,
  input  wire logic       link_10_ok,
  input  wire logic       autoneg_done,
  input  wire logic [3:0] line_rx_data,
  output logic [3:0]      line_tx_data,
  output logic            line_tx_enable,
  output logic            line_tx_power_down,
  // MAC side
  input  wire logic       rx_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  output logic [3:0]      rxd,
  output logic            crs,
  output logic            crs_dv,
  output logic            col,
  output logic            link_indicator_out,
  output logic            link_up_out
);

  typedef enum logic [1:0] {
    LS_DOWN  = 2'b00,
    LS_WAIT  = 2'b01,
    LS_READY = 2'b11,
    LS_UP    = 2'b10
  } link_state_e;

  typedef enum logic [1:0] {
    CS_IDLE   = 2'b00,
    CS_DETECT = 2'b01,
    CS_STREAM = 2'b11,
    CS_ENDING = 2'b10
  } crs_state_e;

  // Pin synchronisers: first stage feeds only the second
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {rx_clk, tx_en, rx_code_bit, signal_good, link_10_ok};
      sync2_r <= sync1_r;
    end
  end
  logic rxc_s;
  logic txen_s;
  logic rxbit_s;
  logic sig_s;
  logic l10_s;
  assign {rxc_s, txen_s, rxbit_s, sig_s, l10_s} = sync2_r;

  // Registers
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic [15:0] mcs_r;
  logic [15:0] mcs_nxt;
  logic        loopback;
  logic        full_duplex;
  logic        coltest;
  logic        autoneg_en;
  logic        remote_echo;
  logic        link_status;

  assign loopback    = ctl_r[CTL_LOOPBACK_BIT];
  assign autoneg_en  = ctl_r[CTL_AUTONEG_BIT];
  assign full_duplex = ctl_r[CTL_DUPLEX_BIT];
  assign coltest     = ctl_r[CTL_COLTEST_BIT];
  // Echo is only honoured in RMII mode; MII setting is ignored
  assign remote_echo = mcs_r[MCS_REMOTE_ECHO_BIT] & rmii_mode;

  always_comb begin
    ctl_nxt = ctl_r;
    mcs_nxt = mcs_r;
    if (reg_write && reg_index == REG_PHY_CONTROL) begin
      ctl_nxt = reg_wdata;
    end
    if (reg_write && reg_index == REG_MODE_CTRL_STS) begin
      mcs_nxt = (mcs_r & ~MCS_WRITE_MASK) | (reg_wdata & MCS_WRITE_MASK);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= CTL_RESET;
      mcs_r <= MCS_RESET;
    end else begin
      ctl_r <= ctl_nxt;
      mcs_r <= mcs_nxt;
    end
  end

  always_comb begin
    case (reg_index)
      REG_PHY_CONTROL:   reg_rdata = ctl_r;
      REG_PHY_STATUS:    reg_rdata = STS_CONST |
                         (16'(link_status) << STS_LINK_BIT);
      REG_MODE_CTRL_STS: reg_rdata = mcs_r;
      default:           reg_rdata = 16'h0000;
    endcase
  end

  // Link monitor
  link_state_e ls_r;
  link_state_e ls_nxt;
  logic        wait_done;

  link_ready_timer #(
    .WAIT_CYC (int'(LINK_WAIT))
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (sig_s && ls_r == LS_WAIT),
    .done  (wait_done)
  );

  always_comb begin
    ls_nxt = ls_r;
    if (!sig_s) begin
      ls_nxt = LS_DOWN;
    end else begin
      case (ls_r)
        LS_DOWN:  ls_nxt = autoneg_en ? LS_WAIT : LS_UP;
        LS_WAIT:  if (wait_done) ls_nxt = LS_READY;
        LS_READY: if (autoneg_done) ls_nxt = LS_UP;
        LS_UP:    ls_nxt = LS_UP;
        default:  ls_nxt = LS_DOWN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_r <= LS_DOWN;
    end else begin
      ls_r <= ls_nxt;
    end
  end

  // Link mux: combinational so loss of signal drops link a cycle before the state
  assign link_status = speed_10 ? l10_s : (ls_r == LS_UP) && sig_s;

  // Carrier detector on the unscrambled code-group bit stream
  crs_state_e  cs_r;
  crs_state_e  cs_nxt;
  logic [9:0]  hist_r;
  logic [9:0]  hist_nxt;
  logic [3:0]  ones_r;
  logic [3:0]  ones_nxt;
  logic [2:0]  bitc_r;
  logic [2:0]  bitc_nxt;
  logic [4:0]  prev_r;
  logic [4:0]  prev_nxt;
  logic        rx_act;
  logic [4:0]  sym;
  logic        sym_strobe;

  // Two zeros in the span that are not adjacent to each other, or three or more zeros anywhere in it
  function automatic logic nonadj_zeros(input logic [9:0] h);
    logic [9:0] z;
    int         cnt;
    logic       adj;
    z   = ~h;
    cnt = 0;
    adj = 1'b0;
    for (int i = 0; i < CRS_SPAN_BITS; i++) begin
      cnt = cnt + int'(z[i]);
    end
    for (int i = 0; i < CRS_SPAN_BITS - 1; i++) begin
      adj = adj | (z[i] & z[i+1]);
    end
    return (cnt >= 3) || (cnt == 2 && !adj);
  endfunction

  assign sym        = hist_r[4:0];
  assign sym_strobe = (bitc_r == 3'd4);

  always_comb begin
    hist_nxt = {hist_r[8:0], rxbit_s};
    ones_nxt = rxbit_s ? ((ones_r == 4'(CRS_ONES_BITS)) ? ones_r :
               ones_r + 4'h1) : 4'h0;
    bitc_nxt = (bitc_r == 3'd4) ? 3'd0 : bitc_r + 3'd1;
    prev_nxt = prev_r;
    cs_nxt   = cs_r;
    case (cs_r)
      CS_IDLE: begin
        if (nonadj_zeros(hist_r)) begin
          cs_nxt   = CS_DETECT;
          bitc_nxt = 3'd0;
          prev_nxt = sym;
        end
      end
      CS_DETECT: begin
        if (ones_r == 4'(CRS_ONES_BITS)) begin
          cs_nxt = CS_IDLE;
        end else if (sym_strobe) begin
          if (prev_r == CG_J && sym == CG_K) begin
            cs_nxt = CS_STREAM;
          end
          prev_nxt = sym;
        end
      end
      CS_STREAM: begin
        if (sym_strobe) begin
          if (sym == CG_T || sym == CG_IDLE) begin
            cs_nxt = CS_ENDING;
          end
          prev_nxt = sym;
        end
      end
      CS_ENDING: begin
        if (sym_strobe) begin
          if ((prev_r == CG_T && sym == CG_R) ||
              (prev_r == CG_IDLE && sym == CG_IDLE)) begin
            cs_nxt = CS_IDLE;
          end else begin
            cs_nxt = CS_STREAM;
          end
          prev_nxt = sym;
        end
      end
      default: cs_nxt = CS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_r   <= CS_IDLE;
      hist_r <= 10'h3ff;
      ones_r <= 4'h0;
      bitc_r <= 3'd0;
      prev_r <= CG_IDLE;
    end else begin
      cs_r   <= cs_nxt;
      hist_r <= hist_nxt;
      ones_r <= ones_nxt;
      bitc_r <= bitc_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Negated once /T/ or the first idle is seen; restored if not paired
  assign rx_act = (cs_r == CS_DETECT) || (cs_r == CS_STREAM);

  // Carrier: duplex/repeater select, changed on receive clock edges
  logic rxc_d_r;
  logic crs_r;
  logic crs_nxt;
  logic crs_src;

  assign crs_src = (full_duplex || repeater_mode) ? rx_act :
                   (rx_act || (txen_s && !loopback));

  always_comb begin
    crs_nxt = crs_r;
    if (rxc_s && !rxc_d_r) begin
      crs_nxt = crs_src & ~remote_echo;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxc_d_r <= 1'b0;
      crs_r   <= 1'b0;
    end else begin
      rxc_d_r <= rxc_s;
      crs_r   <= crs_nxt;
    end
  end

  assign crs    = rmii_mode ? 1'b0 : crs_r;
  assign crs_dv = rmii_mode ? crs_r : 1'b0;

  // Collision: gated from activity levels, not retimed to rx/tx clock
  logic col_src;
  assign col_src = coltest ? txen_s :
                   (loopback || full_duplex) ? 1'b0 :
                   (txen_s && rx_act);
  assign col = col_src & ~remote_echo;

  // Datapath: near-end loopback and remote echo
  logic [3:0] rxd_r;
  logic [3:0] rxd_nxt;
  logic [3:0] ltx_r;
  logic [3:0] ltx_nxt;
  logic       lten_r;
  logic       lten_nxt;

  always_comb begin
    rxd_nxt  = loopback ? txd : line_rx_data;
    ltx_nxt  = remote_echo ? line_rx_data : txd;
    lten_nxt = remote_echo ? rx_act : (txen_s && !loopback);
    if (remote_echo) begin
      rxd_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd_r  <= 4'h0;
      ltx_r  <= 4'h0;
      lten_r <= 1'b0;
    end else begin
      rxd_r  <= rxd_nxt;
      ltx_r  <= ltx_nxt;
      lten_r <= lten_nxt;
    end
  end

  assign rxd                = rxd_r;
  assign line_tx_data       = ltx_r;
  assign line_tx_enable     = lten_r;
  assign line_tx_power_down = loopback;
  assign link_indicator_out = link_status;
  assign link_up_out        = (ls_r == LS_UP);

endmodule

//--- logic/phy_link_pkg.sv
/*
  Constants shared by the carrier, collision, link-monitor and loopback
  logic: register indices, control bit positions, code groups and timing.
  Assumes a 25 MHz core clock; the MAC interface is MII or RMII.
*/
package phy_link_pkg;

  // Register indices on the management port
  localparam logic [4:0] REG_PHY_CONTROL   = 5'h00;
  localparam logic [4:0] REG_PHY_STATUS    = 5'h01;
  localparam logic [4:0] REG_MODE_CTRL_STS = 5'h11;

  // phy_control bits
  localparam int CTL_LOOPBACK_BIT  = 14;
  localparam int CTL_AUTONEG_BIT   = 12;
  localparam int CTL_DUPLEX_BIT    = 8;
  localparam int CTL_COLTEST_BIT   = 7;
  localparam logic [15:0] CTL_RESET = 16'h1000;

  // phy_status bits
  localparam int STS_LINK_BIT      = 2;
  localparam logic [15:0] STS_CONST = 16'h7800;

  // mode_control_status bits
  localparam int MCS_REMOTE_ECHO_BIT = 9;
  localparam logic [15:0] MCS_WRITE_MASK = 16'h0200;
  localparam logic [15:0] MCS_RESET      = 16'h0000;

  // 5-bit code groups
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0d;
  localparam logic [4:0] CG_R    = 5'h07;

  // Carrier detector windows
  localparam int CRS_SPAN_BITS = 10;
  localparam int CRS_ONES_BITS = 10;

  // Timing
  localparam int CLK_HZ            = 25000000;
  localparam int LINK_WAIT_MS      = 330;
  localparam longint LINK_WAIT_CYC =
    (longint'(LINK_WAIT_MS) * CLK_HZ + 999) / 1000;
  localparam int COLTEST_RISE_BT   = 512;
  localparam int COLTEST_FALL_BT   = 4;

endpackage

//--- test/mac_partner.sv
/*
  MAC partner: transmit enable and data, a free receive clock.
  Assumes the core clock paces its transmit changes.
*/
`timescale 1ns/1ns
module mac_partner (
  input wire logic  clk,
  input wire logic  col,
  output logic       rx_clk,
  output logic       tx_en,
  output logic [3:0] txd,
  output logic       col_s
);
  logic col_m;
  initial begin
    rx_clk = 0;
    tx_en = 0;
    txd = 0;
  end
  // Phase offset keeps receive clock edges off the core clock edges
  initial #7 forever #160 rx_clk = ~rx_clk;
  // Collision is asynchronous, so it passes two flops first
  always @(posedge clk) begin
    col_m <= col;
    col_s <= col_m;
  end
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    tx_en <= 1;
    txd <= v;
  endtask
  // Released data turns over, so a stale nibble cannot pass as valid
  task automatic stop_tx();
    @(posedge clk);
    tx_en <= 0;
    txd <= ~txd;
  endtask
endmodule

//--- test/phy_carrier_col_link_loopback_bench.sv
/*
  Bench for the carrier, collision and link block with a MAC partner.
  Assumes the package, design, partner and checker are compiled first.
*/
`timescale 1ns/1ns
module phy_carrier_col_link_loopback_bench
  import phy_link_pkg::*;
;
  localparam longint LW = 20;
  localparam logic [4:0] DG = 5'h0e;
  logic        clk = 0, rst = 1, reg_write = 0, rmii_mode = 0;
  logic [4:0]  reg_index = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, rv;
  logic        repeater_mode = 0, speed_10 = 0, rx_code_bit = 1;
  logic        signal_good = 0, link_10_ok = 0, autoneg_done = 0;
  logic [3:0]  line_rx_data = 0, line_tx_data, rxd, txd, v;
  logic        line_tx_enable, line_tx_power_down, rx_clk, tx_en, col_s;
  logic        crs, crs_dv, col, link_indicator_out, link_up_out;
  int          bad_count = 0, n_checks = 0, cyc = 0, n;
  phy_carrier_col_link_loopback #(.LINK_WAIT(LW)) uut (.clk, .rst,
    .reg_index, .reg_write, .reg_wdata, .reg_rdata, .rmii_mode,
    .repeater_mode, .speed_10, .rx_code_bit, .signal_good, .link_10_ok,
    .autoneg_done, .line_rx_data, .line_tx_data, .line_tx_enable,
    .line_tx_power_down, .rx_clk, .tx_en, .txd, .rxd, .crs, .crs_dv, .col,
    .link_indicator_out, .link_up_out);
  mac_partner mac (.clk, .col, .rx_clk, .tx_en, .txd, .col_s);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    reg_index <= i;
    reg_write <= 1;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 0;
  endtask
  task automatic rd(input logic [4:0] i);
    @(posedge clk);
    reg_index <= i;
    hold(1);
    rv = reg_rdata;
  endtask
  task automatic send(input logic [4:0] q[$]);
    foreach (q[i])
      for (int b = 4; b >= 0; b--) begin
        @(posedge clk);
        rx_code_bit <= q[i][b];
      end
  endtask
  // Carrier expected at the end of a stream of code groups
  function automatic logic model_crs(input logic [4:0] q[$]);
    int on = 0, ssd = 0;
    logic [4:0] p = CG_IDLE;
    foreach (q[i]) begin
      if (!on && q[i] != CG_IDLE)
        on = 1;
      else if (on && !ssd && p == CG_J && q[i] == CG_K)
        ssd = 1;
      else if (on && ((p == CG_T && q[i] == CG_R && ssd)
          || (p == CG_IDLE && q[i] == CG_IDLE))) begin
        on = 0;
        ssd = 0;
      end
      p = q[i];
    end
    return on[0];
  endfunction
  task automatic strm(input logic [4:0] q[$]);
    send(q);
    // Repeating the last group keeps the state while carrier is retimed
    repeat (4) send('{q[$]});
    #1;
    chk("carrier", model_crs(q), rmii_mode ? crs_dv : crs);
    chk("idle pin", 0, rmii_mode ? crs : crs_dv);
    send('{CG_T, CG_R, CG_IDLE, CG_IDLE, CG_IDLE, CG_IDLE});
  endtask
  initial begin
    void'($urandom(32'h54c6));
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(REG_PHY_CONTROL);
    chk("ctl", CTL_RESET, rv);
    rd(5'h05);
    chk("unmapped", 0, rv);
    wr(REG_MODE_CTRL_STS, 16'hffff);
    rd(REG_MODE_CTRL_STS);
    chk("mcs", MCS_WRITE_MASK, rv);
    rd(REG_PHY_STATUS);
    chk("sts", STS_CONST, rv);
    wr(REG_MODE_CTRL_STS, 0);
    wr(REG_PHY_CONTROL, 0);
    strm('{CG_J, CG_K, DG, DG, CG_T, DG, DG, DG, DG});
    strm('{CG_J, CG_K, DG, CG_T, CG_R, CG_IDLE, CG_IDLE});
    strm('{CG_J, CG_K, DG, CG_IDLE, DG, DG, DG, DG});
    strm('{5'h15, CG_IDLE, CG_IDLE, CG_IDLE});
    for (int k = 0; k < 3; k++) begin
      wr(REG_PHY_CONTROL, k == 2 ? 16'h0100 : 16'h0000);
      repeater_mode <= (k == 1);
      mac.drive(4'($urandom));
      hold(24);
      chk("tx carrier", k == 0, crs);
      send('{CG_J, CG_K, DG, DG, DG, DG});
      hold(4);
      chk("collision", k != 2, col_s);
      mac.stop_tx();
      send('{CG_T, CG_R, CG_IDLE, CG_IDLE, CG_IDLE});
    end
    wr(REG_PHY_CONTROL, 16'h4080);
    repeater_mode <= 0;
    v = 4'($urandom);
    mac.drive(v);
    hold(8);
    chk("power down", 1, line_tx_power_down);
    chk("loop data", v, rxd);
    chk("test col", 1, col_s);
    mac.stop_tx();
    hold(4);
    chk("test col end", 0, col_s);
    wr(REG_PHY_CONTROL, 16'h4000);
    mac.drive(v);
    hold(8);
    send('{CG_J, CG_K, DG, DG, DG, DG});
    hold(4);
    chk("loop col", 0, col_s);
    mac.stop_tx();
    send('{CG_T, CG_R, CG_IDLE, CG_IDLE, CG_IDLE});
    wr(REG_PHY_CONTROL, 0);
    // Echo bit set in MII mode must leave the transmit path alone
    wr(REG_MODE_CTRL_STS, MCS_WRITE_MASK);
    line_rx_data <= ~txd;
    hold(8);
    chk("mii echo", txd, line_tx_data);
    @(posedge clk);
    rmii_mode <= 1;
    line_rx_data <= 4'($urandom);
    hold(8);
    chk("echo", line_rx_data, line_tx_data);
    chk("echo rxd", 0, rxd);
    wr(REG_MODE_CTRL_STS, 0);
    strm('{CG_J, CG_K, DG, DG, DG});
    rmii_mode <= 0;
    signal_good <= 1;
    hold(6);
    chk("link", 1, link_indicator_out);
    rd(REG_PHY_STATUS);
    chk("status link", 1, rv[STS_LINK_BIT]);
    @(posedge clk);
    signal_good <= 0;
    hold(3);
    chk("link drop", 0, link_indicator_out);
    wr(REG_PHY_CONTROL, CTL_RESET);
    signal_good <= 1;
    hold(LW + 10);
    chk("no enable", 0, link_up_out);
    @(posedge clk);
    autoneg_done <= 1;
    hold(4);
    chk("enabled", 1, link_up_out);
    @(posedge clk);
    signal_good <= 0;
    hold(4);
    @(posedge clk);
    signal_good <= 1;
    for (n = 0; n < 200 && link_up_out !== 1; n++)
      hold(1);
    chk("ready wait", 1, n >= LW && n < 200);
    speed_10 <= 1;
    repeat (4) begin
      @(posedge clk);
      link_10_ok <= 1'($urandom);
      hold(4);
      chk("link 10", link_10_ok, link_indicator_out);
    end
    close_out();
  end
endmodule

//--- test/phy_link_props.sv
/*
  Port checker for the carrier, collision and link block.
  Assumes a bind to the top module; it sees only that module's ports.
*/
`timescale 1ns/1ns
module phy_link_props
  import phy_link_pkg::*;
#(
  parameter longint LINK_WAIT = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [4:0]  reg_index,
  input wire logic        reg_write,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        rmii_mode,
  input wire logic        speed_10,
  input wire logic        signal_good,
  input wire logic        link_10_ok,
  input wire logic        tx_en,
  input wire logic        crs_dv,
  input wire logic        col,
  input wire logic        line_tx_power_down,
  input wire logic        link_indicator_out,
  input wire logic        link_up_out
);
  logic [15:0] ctl_r;
  logic        echo_r;
  longint      sg_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Mirrors of the control bits, so the properties see the mode in force
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= CTL_RESET;
      echo_r <= 1'b0;
      sg_cnt_r <= 0;
    end else begin
      if (reg_write && reg_index == REG_PHY_CONTROL)
        ctl_r <= reg_wdata;
      if (reg_write && reg_index == REG_MODE_CTRL_STS)
        echo_r <= reg_wdata[MCS_REMOTE_ECHO_BIT];
      sg_cnt_r <= signal_good ? sg_cnt_r + 1 : 0;
    end
  end
  dup_col_low_a: assert property (ctl_r[8] && !ctl_r[7] |-> !col)
    else $error("collision seen in full duplex");
  loop_col_low_a: assert property (ctl_r[14] && !ctl_r[7] |-> !col)
    else $error("collision seen in loopback");
  tx_power_a: assert property (line_tx_power_down == ctl_r[14])
    else $error("transmitter power does not follow loopback");
  col_test_rise_a: assert property (ctl_r[7] && !ctl_r[8] && !echo_r
    && $rose(tx_en) |-> ##[1:128] col) else $error("test collision late");
  col_test_fall_a: assert property (ctl_r[7] && $fell(tx_en)
    |-> ##[1:3] !col) else $error("test collision stuck");
  link_drop_a: assert property (!speed_10 && $fell(signal_good)
    |-> ##[1:3] !link_indicator_out) else $error("link held");
  link_ten_a: assert property ((speed_10 && link_10_ok)[*4]
    |-> link_indicator_out) else $error("10M link not shown");
  ready_wait_a: assert property ($rose(link_up_out) && ctl_r[12]
    |-> sg_cnt_r >= LINK_WAIT) else $error("link up too early");
  direct_up_a: assert property (!ctl_r[12] && !speed_10
    && $rose(signal_good) |-> ##[1:5] link_up_out) else $error("no link");
  status_link_a: assert property (reg_index == REG_PHY_STATUS
    |-> reg_rdata[STS_LINK_BIT] == link_indicator_out)
    else $error("status link bit differs");
  mii_crs_a: assert property (!rmii_mode |-> !crs_dv)
    else $error("carrier on wrong pin");
  cover property ($rose(col));
  cover property ($rose(link_up_out));
  cover property ($fell(crs_dv));
endmodule
bind phy_carrier_col_link_loopback phy_link_props #(.LINK_WAIT(LINK_WAIT))
  chk_i (.clk, .rst, .reg_index, .reg_write, .reg_wdata, .reg_rdata,
  .rmii_mode, .speed_10, .signal_good, .link_10_ok, .tx_en, .crs_dv, .col,
  .line_tx_power_down, .link_indicator_out, .link_up_out);
